// File: cp_and_vco_vco_auto_calibration_config.sv
// Purpose: Charge pump and VCO auto-calibration configuration bank
// Assumes: CLK_SYS stands for the crystal reference clock
// Notes:   Calibration search is a digital model driven by VCO_FAST
//
// Local design decision: the AXI4-Lite slave port.
module cp_and_vco_vco_auto_calibration_config
  import cpcal_pkg::*;
(
  input  wire logic              CLK_SYS,
  input  wire logic              RESET_N,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [DATA_W-1:0] WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [DATA_W-1:0]      RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              VCO_FAST,
  output cp_ctrl_s               PUMP_CTRL,
  output cal_cfg_s               CAL_CFG,
  output logic [11:0]            PUMP_DN_UA,
  output logic [11:0]            PUMP_UP_UA,
  output logic [9:0]             OFFSET_UA,
  output logic [8:0]             MEAS_CYCLES,
  output logic [3:0]             SAR_BITS,
  output logic [5:0]             FSM_DIV,
  output logic [7:0]             VCO_CURVE,
  output logic                   CAL_BUSY,
  output logic                   SERIAL_START
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  // Register index from a byte address
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    return {2'h0, a[ADDR_W-1:2]};
  endfunction

  // Byte-lane merge of a write into a 24-bit register
  function automatic logic [23:0] merge(input logic [23:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++)
      if (s[i])
        r[i*8 +: 8] = d[i*8 +: 8];
    return r;
  endfunction

  // Pump gain code to microamps
  function automatic logic [11:0] pump_ua(input logic [6:0] c);
    return 12'(c) * PUMP_STEP_UA;
  endfunction

  // Resolution code to measurement length in divider cycles
  function automatic logic [8:0] meas_len(input logic [2:0] c);
    case (c)
      3'h0:    return 9'h001;
      3'h1:    return 9'h002;
      3'h2:    return 9'h004;
      3'h3:    return 9'h008;
      3'h4:    return 9'h020;
      3'h5:    return 9'h040;
      3'h6:    return 9'h080;
      default: return 9'h100;
    endcase
  endfunction

  // Clock select code to division ratio
  function automatic logic [5:0] div_ratio(input logic [1:0] c);
    case (c)
      2'h0:    return 6'h01;
      2'h1:    return 6'h04;
      2'h2:    return 6'h10;
      default: return 6'h20;
    endcase
  endfunction

  // Temperature curve offset, saturated to the curve range
  function automatic logic [7:0] adj_curve(input logic [7:0] c,
                                           input logic [2:0] a);
    logic signed [9:0] s;
    s = $signed({2'h0, c}) + $signed({{7{a[2]}}, a});
    if (s < 0)
      return 8'h00;
    else if (s > 10'sh0ff)
      return 8'hff;
    return s[7:0];
  endfunction

  cp_ctrl_s    pump_ff;      // Charge pump register
  cal_cfg_s    cal_ff;       // Calibration configuration
  logic [23:0] tune_ff;      // Tuning register, low byte is the curve
  logic        aw_have_ff;   // Write address held
  logic [7:0]  aw_addr_ff;   // Held write address
  logic        w_have_ff;    // Write data held
  logic [31:0] w_data_ff;    // Held write data
  logic [3:0]  w_strb_ff;    // Held byte enables
  logic        bvalid_ff;    // Write response pending
  logic [1:0]  bresp_ff;     // Write response code
  logic        rvalid_ff;    // Read data pending
  logic [31:0] rdata_ff;     // Read data
  logic [1:0]  rresp_ff;     // Read response code
  logic [4:0]  div_cnt_ff;   // Reference divider count
  logic        pend_ff;      // Calibration start pending
  cal_state_e  st_ff;        // Calibration state
  logic [8:0]  cnt_ff;       // Wait or measurement countdown
  logic [7:0]  bit_ff;       // Bit under trial
  logic [7:0]  trial_ff;     // Curve under trial
  logic [1:0]  midx_ff;      // Measurements done, saturating
  logic [7:0]  curve_ff;     // Curve last sent
  logic        send_ff;      // Serial transfer start pulse
  logic        do_write;     // Write performed this cycle
  logic [7:0]  wr_idx;       // Index being written
  logic [7:0]  rd_idx;       // Index being read
  logic        tune_write;   // Write to the tuning register
  logic        fsm_tick;     // State machine clock enable
  logic [4:0]  div_lim;      // Divider terminal count
  logic        consume;      // Pending start taken
  logic [7:0]  next_trial;   // Trial after the comparison

  // Handshake outputs come straight from the holding state
  assign AWREADY  = !aw_have_ff && !bvalid_ff;
  assign WREADY   = !w_have_ff && !bvalid_ff;
  assign ARREADY  = !rvalid_ff;
  assign BVALID   = bvalid_ff;
  assign BRESP    = bresp_ff;
  assign RVALID   = rvalid_ff;
  assign RDATA    = rdata_ff;
  assign RRESP    = rresp_ff;
  assign do_write = aw_have_ff && w_have_ff && !bvalid_ff;
  assign wr_idx   = reg_idx(aw_addr_ff);
  assign rd_idx   = reg_idx(ARADDR);
  assign tune_write = do_write && (wr_idx == IDX_TUNE);
  assign PUMP_CTRL  = pump_ff;
  assign CAL_CFG    = cal_ff;
  assign VCO_CURVE  = curve_ff;
  assign SERIAL_START = send_ff;
  assign CAL_BUSY   = (st_ff != ST_IDLE);

  // Address and data are taken in either order and held
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_have_ff  <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
    end
    else
    begin
      if (AWVALID && AWREADY)
      begin
        aw_have_ff <= 1'b1;
        aw_addr_ff <= AWADDR;
      end
      else if (do_write)
        aw_have_ff <= 1'b0;
      if (WVALID && WREADY)
      begin
        w_have_ff <= 1'b1;
        w_data_ff <= WDATA;
        w_strb_ff <= WSTRB;
      end
      else if (do_write)
        w_have_ff <= 1'b0;
    end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end
    else if (do_write)
    begin
      bvalid_ff <= 1'b1;
      if (wr_idx == IDX_TUNE || wr_idx == IDX_PUMP ||
          wr_idx == IDX_CAL || wr_idx == IDX_STAT)
        bresp_ff <= RESP_OKAY;
      else
        bresp_ff <= RESP_SLVERR;
    end
    else if (BREADY)
      bvalid_ff <= 1'b0;

  // Register storage; status is read-only and ignores writes
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      pump_ff <= cp_ctrl_s'(PUMP_RST);
      cal_ff  <= cal_cfg_s'(CAL_RST);
      tune_ff <= TUNE_RST;
    end
    else if (do_write)
    begin
      if (wr_idx == IDX_PUMP)
        pump_ff <= cp_ctrl_s'(merge(pump_ff, w_data_ff, w_strb_ff));
      else if (wr_idx == IDX_CAL)
        cal_ff <= cal_cfg_s'(merge(cal_ff, w_data_ff, w_strb_ff));
      else if (wr_idx == IDX_TUNE)
        tune_ff <= merge(tune_ff, w_data_ff, w_strb_ff);
    end

  // Read channel; data is captured at the address handshake
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= RESP_OKAY;
    end
    else if (ARVALID && ARREADY)
    begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
      if (rd_idx == IDX_PUMP)
        rdata_ff <= {8'h00, pump_ff};
      else if (rd_idx == IDX_CAL)
        rdata_ff <= {8'h00, cal_ff};
      else if (rd_idx == IDX_TUNE)
        rdata_ff <= {8'h00, tune_ff};
      else if (rd_idx == IDX_STAT)
      begin
        rdata_ff[7:0]       <= curve_ff;
        rdata_ff[STAT_BUSY] <= CAL_BUSY;
        rdata_ff[STAT_PEND] <= pend_ff;
      end
      else
        rresp_ff <= RESP_SLVERR;
    end
    else if (RREADY)
      rvalid_ff <= 1'b0;

  // Decoded currents and lengths, registered for clean outputs
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      PUMP_DN_UA  <= 12'h000;
      PUMP_UP_UA  <= 12'h000;
      OFFSET_UA   <= 10'h000;
      MEAS_CYCLES <= 9'h000;
      SAR_BITS    <= 4'h0;
      FSM_DIV     <= 6'h00;
    end
    else
    begin
      PUMP_DN_UA  <= pump_ua(pump_ff.pump_down_gain);
      PUMP_UP_UA  <= pump_ua(pump_ff.pump_up_gain);
      OFFSET_UA   <= 10'(pump_ff.offset_mag) * OFS_STEP_UA;
      MEAS_CYCLES <= meas_len(cal_ff.vtune_res);
      SAR_BITS    <= MAX_SAR - {2'h0, cal_ff.sar_depth};
      FSM_DIV     <= div_ratio(cal_ff.clk_sel);
    end

  // divided reference as a tick enable
  assign div_lim  = 5'(div_ratio(cal_ff.clk_sel) - 6'h01);
  assign fsm_tick = (div_cnt_ff >= div_lim);

  // Divider; wraps early if the ratio shrinks mid-count
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
      div_cnt_ff <= 5'h00;
    else if (fsm_tick)
      div_cnt_ff <= 5'h00;
    else
      div_cnt_ff <= div_cnt_ff + 5'h01;

  // tuning writes start a run unless blocked
  // bypass never arms a run; a new write wins over consume
  assign consume = fsm_tick && (st_ff == ST_IDLE) && pend_ff;
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
      pend_ff <= 1'b0;
    else if (tune_write && !cal_ff.no_trigger && !cal_ff.bypass_tune)
      pend_ff <= 1'b1;
    else if (consume)
      pend_ff <= 1'b0;

  // Comparison result clears the trial bit when the VCO runs fast
  assign next_trial = VCO_FAST ? (trial_ff & ~bit_ff) : trial_ff;

  // Calibration state machine, advancing on divided ticks
  always_ff @(posedge CLK_SYS or negedge RESET_N)
    if (!RESET_N)
    begin
      st_ff    <= ST_IDLE;
      cnt_ff   <= 9'h000;
      bit_ff   <= 8'h00;
      trial_ff <= 8'h00;
      midx_ff  <= 2'h0;
      curve_ff <= 8'h00;
      send_ff  <= 1'b0;
    end
    else
    begin
      send_ff <= 1'b0;
      if (fsm_tick)
        case (st_ff)
          ST_IDLE:
            if (pend_ff && cal_ff.force_curve)
            begin
              curve_ff <= tune_ff[7:0];
              send_ff  <= 1'b1;
            end
            else if (pend_ff)
            begin
              st_ff    <= ST_WAIT;
              cnt_ff   <= WAIT_TICKS - 9'h001;
              // top trial bit from the depth
              bit_ff   <= TOP_BIT >> cal_ff.sar_depth;
              trial_ff <= TOP_BIT >> cal_ff.sar_depth;
              midx_ff  <= 2'h0;
            end
          ST_WAIT:
            if (cnt_ff == 9'h000)
            begin
              st_ff  <= ST_MEAS;
              cnt_ff <= meas_len(cal_ff.vtune_res) - 9'h001;
            end
            else
              cnt_ff <= cnt_ff - 9'h001;
          ST_MEAS:
            if (cnt_ff != 9'h000)
              cnt_ff <= cnt_ff - 9'h001;
            else if (bit_ff == LAST_BIT)
            begin
              trial_ff <= next_trial;
              st_ff    <= ST_SEND;
            end
            else
            begin
              trial_ff <= next_trial | (bit_ff >> 1);
              bit_ff   <= bit_ff >> 1;
              if (midx_ff != 2'h3)
                midx_ff <= midx_ff + 2'h1;
              if (midx_ff < cal_ff.wait_code)
              begin
                st_ff  <= ST_WAIT;
                cnt_ff <= WAIT_TICKS - 9'h001;
              end
              else
                cnt_ff <= meas_len(cal_ff.vtune_res) - 9'h001;
            end
          default:
          begin
            curve_ff <= adj_curve(trial_ff, cal_ff.curve_adj);
            send_ff  <= 1'b1;
            st_ff    <= ST_IDLE;
          end
        endcase
    end

  // Gated on sampled reset: the release edge still loads reset values
  chk_down_gain_scale: assert property (
    RESET_N |=>
      PUMP_DN_UA == 12'($past(pump_ff.pump_down_gain)) * PUMP_STEP_UA)
    else $error("down current scale wrong");
  chk_up_gain_scale: assert property (
    RESET_N |=>
      PUMP_UP_UA == 12'($past(pump_ff.pump_up_gain)) * PUMP_STEP_UA)
    else $error("up current scale wrong");
  // Decode lags the register by one cycle, so compare with the past value
  chk_offset_scale: assert property (
    RESET_N |=>
      OFFSET_UA == 10'($past(pump_ff.offset_mag)) * OFS_STEP_UA)
    else $error("offset current scale wrong");
  chk_high_pump_write: assert property (
    do_write && wr_idx == IDX_PUMP && w_strb_ff[2]
    |=> PUMP_CTRL.high_current == $past(w_data_ff[23]))
    else $error("high current bit not written");
  chk_meas_length: assert property (
    st_ff == ST_WAIT && fsm_tick && cnt_ff == 9'h000
    |=> cnt_ff == meas_len(cal_ff.vtune_res) - 9'h001)
    else $error("measurement length wrong");
  chk_wait_after_meas: assert property (
    st_ff == ST_MEAS && fsm_tick && cnt_ff == 9'h000 &&
    bit_ff != LAST_BIT && midx_ff < cal_ff.wait_code
    |=> st_ff == ST_WAIT && cnt_ff == WAIT_TICKS - 9'h001)
    else $error("wait state not inserted");
  chk_sar_start_bit: assert property (
    st_ff == ST_IDLE && consume && !cal_ff.force_curve
    |=> bit_ff == (TOP_BIT >> $past(cal_ff.sar_depth)) && st_ff == ST_WAIT)
    else $error("search depth wrong");
  chk_force_send: assert property (
    consume && cal_ff.force_curve
    |=> SERIAL_START && VCO_CURVE == $past(tune_ff[7:0]) ##1 !SERIAL_START)
    else $error("forced curve not sent");
  chk_no_trigger: assert property (
    tune_write && cal_ff.no_trigger && !pend_ff |=> !pend_ff)
    else $error("blocked write started a run");
  // A new ratio may wrap the divider early, so the select must hold
  chk_tick_spacing: assert property (
    fsm_tick && cal_ff.clk_sel == 2'h1 ##1 (cal_ff.clk_sel == 2'h1) [*3]
    |-> !fsm_tick && !$past(fsm_tick) && !$past(fsm_tick, 2))
    else $error("divide by four tick spacing wrong");
  chk_bypass_idle: assert property (
    cal_ff.bypass_tune && st_ff == ST_IDLE && !pend_ff
    |=> st_ff == ST_IDLE && $stable(VCO_CURVE))
    else $error("bypass did not hold tuning");
endmodule

// File: cpcal_pkg.sv
// Purpose: Constants and types for the pump and calibration register bank
// Assumes: AXI4-Lite slave, 32-bit data, byte address = 4 * index
// Notes:   Rule summary below
// Operation
// - Down gain sets sink current, 20 uA steps
// - Up gain sets source current, 20 uA steps
// - Offset magnitude sets offset current, 5 uA steps
// - Bit 23 selects high current pump
// - Resolution code sets measurement length in cycles
// - Curve adjust code offsets the calibrated curve
// - Wait code inserts 100-tick waits after measurements
// - Depth code selects 8 down to 5 bits
// - Force bit sends stored curve, skips search
// - No-trigger bit blocks start on tuning writes
// - Clock select divides reference by 1/4/16/32
// - Bit 15 holds the falling edge select; the calibration logic here still runs on the rising edge
// - Bit 16 holds the divider bypass flag; the reference divider still divides by the clock select
package cpcal_pkg;
  localparam int unsigned ADDR_W = 8;  // Byte address width
  localparam int unsigned DATA_W = 32; // Bus data width
  localparam int unsigned REG_W  = 24; // Register width
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_TUNE = 8'h05;
  localparam logic [7:0] IDX_PUMP = 8'h09;
  localparam logic [7:0] IDX_CAL  = 8'h0a;
  localparam logic [7:0] IDX_STAT = 8'h10;
  // Reset values
  localparam logic [23:0] PUMP_RST = 24'h403264;
  localparam logic [23:0] CAL_RST  = 24'h002205;
  localparam logic [23:0] TUNE_RST = 24'h000000;
  // Current step sizes in microamps
  localparam logic [11:0] PUMP_STEP_UA = 12'h014;
  localparam logic [9:0]  OFS_STEP_UA  = 10'h005;
  // Wait length in state machine ticks (100)
  localparam logic [8:0] WAIT_TICKS = 9'h064;
  localparam logic [7:0] LAST_BIT   = 8'h01;
  localparam logic [7:0] TOP_BIT    = 8'h80;
  localparam logic [3:0] MAX_SAR    = 4'h8;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Status word fields
  localparam int unsigned STAT_BUSY = 8;
  localparam int unsigned STAT_PEND = 9;

  // Charge pump register layout
  typedef struct packed {
    logic       high_current;
    logic       offset_dn_en;
    logic       offset_up_en;
    logic [6:0] offset_mag;
    logic [6:0] pump_up_gain;
    logic [6:0] pump_down_gain;
  } cp_ctrl_s;

  // Calibration configuration register layout
  typedef struct packed {
    logic [6:0] spare;
    logic       rdiv_bypass;
    logic       falling_edge;
    logic [1:0] clk_sel;
    logic       no_trigger;
    logic       bypass_tune;
    logic       force_curve;
    logic [1:0] sar_depth;
    logic [1:0] wait_code;
    logic [2:0] curve_adj;
    logic [2:0] vtune_res;
  } cal_cfg_s;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_MEAS, ST_SEND} cal_state_e;
endpackage

// File: test_cp_and_vco_vco_auto_calibration_config.sv
// Purpose: Self-checking bench for the pump and calibration register bank
// Assumes: AXI4-Lite access, byte address = 4 * index, CLK_SYS at 20 MHz
// Notes:   Calibration timing is compared as differences between runs
module test_cp_and_vco_vco_auto_calibration_config
  import cpcal_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              CLK_SYS;      // System clock
  logic              RESET_N;      // Active-low reset
  logic [ADDR_W-1:0] AWADDR;       // Write address
  logic              AWVALID;      // Write address valid
  logic              AWREADY;      // Write address ready
  logic [DATA_W-1:0] WDATA;        // Write data
  logic [3:0]        WSTRB;        // Write strobes
  logic              WVALID;       // Write data valid
  logic              WREADY;       // Write data ready
  logic [1:0]        BRESP;        // Write response
  logic              BVALID;       // Write response valid
  logic              BREADY;       // Write response ready
  logic [ADDR_W-1:0] ARADDR;       // Read address
  logic              ARVALID;      // Read address valid
  logic              ARREADY;      // Read address ready
  logic [DATA_W-1:0] RDATA;        // Read data
  logic [1:0]        RRESP;        // Read response
  logic              RVALID;       // Read data valid
  logic              RREADY;       // Read data ready
  logic              VCO_FAST;     // Comparator answer during search
  cp_ctrl_s          PUMP_CTRL;    // Pump register image
  cal_cfg_s          CAL_CFG;      // Calibration register image
  logic [11:0]       PUMP_DN_UA;   // Sink current
  logic [11:0]       PUMP_UP_UA;   // Source current
  logic [9:0]        OFFSET_UA;    // Offset current
  logic [8:0]        MEAS_CYCLES;  // Measurement length
  logic [3:0]        SAR_BITS;     // Search depth
  logic [5:0]        FSM_DIV;      // State machine clock divide
  logic [7:0]        VCO_CURVE;    // Last curve sent
  logic              CAL_BUSY;     // Calibration running
  logic              SERIAL_START; // Serial transfer start pulse
  int                error_cnt;    // Mismatches
  int                n_checks;     // Comparisons made
  int                cycles;       // Timeout counter
  int                starts;       // Count of start pulses
  int                n0;           // Reference run length
  int                n1;           // Second run length
  logic [1:0]        resp;         // Last bus response
  logic [31:0]       rd;           // Last read data
  logic [31:0]       v;            // Pattern under test

  cp_and_vco_vco_auto_calibration_config cp_and_vco_vco_auto_calibration_config_i (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .AWADDR(AWADDR),
    .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB),
    .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
    .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .VCO_FAST(VCO_FAST), .PUMP_CTRL(PUMP_CTRL),
    .CAL_CFG(CAL_CFG), .PUMP_DN_UA(PUMP_DN_UA), .PUMP_UP_UA(PUMP_UP_UA),
    .OFFSET_UA(OFFSET_UA), .MEAS_CYCLES(MEAS_CYCLES), .SAR_BITS(SAR_BITS),
    .FSM_DIV(FSM_DIV), .VCO_CURVE(VCO_CURVE), .CAL_BUSY(CAL_BUSY),
    .SERIAL_START(SERIAL_START));

  // Clock, 50 ns period
  initial
  begin
    CLK_SYS = 1'b0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  // Hang guard; the longest run is a few thousand cycles
  always @(posedge CLK_SYS)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      error_cnt = error_cnt + 1;
      conclude();
    end
  end

  // Start pulses counted apart from the main flow
  always @(posedge CLK_SYS)
    if (SERIAL_START === 1'b1)
      starts <= starts + 1;

  // Verdict and end of run
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare; case inequality keeps unknowns from matching
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Write; handshakes sampled at the falling edge, acted on at the rising
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok;
    logic w_ok;
    logic b_ok;
    @(posedge CLK_SYS);
    AWADDR  <= a;
    WDATA   <= d;
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    b_ok = 1'b0;
    while (!b_ok)
    begin
      @(negedge CLK_SYS);
      aw_ok = AWVALID && (AWREADY === 1'b1);
      w_ok  = WVALID && (WREADY === 1'b1);
      b_ok  = (BVALID === 1'b1);
      resp  = BRESP;
      @(posedge CLK_SYS);
      if (aw_ok) AWVALID <= 1'b0;
      if (w_ok) WVALID <= 1'b0;
      if (b_ok) BREADY <= 1'b0;
    end
  endtask

  // Read; data and response sampled at the falling edge that sees RVALID
  task automatic rdr(input logic [7:0] a);
    logic ar_ok;
    logic r_ok;
    @(posedge CLK_SYS);
    ARADDR  <= a;
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    r_ok = 1'b0;
    while (!r_ok)
    begin
      @(negedge CLK_SYS);
      ar_ok = ARVALID && (ARREADY === 1'b1);
      r_ok  = (RVALID === 1'b1);
      rd    = RDATA;
      resp  = RRESP;
      @(posedge CLK_SYS);
      if (ar_ok) ARVALID <= 1'b0;
      if (r_ok) RREADY <= 1'b0;
    end
  endtask

  // Configure, write tuning word, count cycles up to the start pulse
  task automatic cal(input logic [23:0] c, input logic [7:0] t,
                     input logic f, output int n);
    VCO_FAST <= f;
    wr(8'h28, {8'h00, c});
    wr(8'h14, {24'h000000, t});
    n = 0;
    do
    begin
      @(negedge CLK_SYS);
      n = n + 1;
    end
    while (SERIAL_START !== 1'b1 && n < 3000);
    chk(n < 3000, 32'h1);
  endtask

  // Main sequence
  initial
  begin
    {AWADDR, AWVALID, WDATA, WVALID, BREADY} = '0;
    {ARADDR, ARVALID, RREADY, VCO_FAST} = '0;
    WSTRB = 4'hf;
    error_cnt = 0;
    n_checks = 0;
    cycles = 0;
    starts = 0;
    RESET_N = 1'b0;
    repeat (12) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    // Reset contents and decoded values
    rdr(8'h24);
    chk(rd, 32'h00403264);  // pump reset value
    rdr(8'h28);
    chk(rd, 32'h00002205);  // calibration reset value
    chk(MEAS_CYCLES, 32'd64);  // reset code five
    chk(FSM_DIV, 32'd4);  // reset divide
    chk(PUMP_DN_UA, 32'd2000);  // reset gain
    // Pump field extremes; top byte reads back zero
    for (int i = 0; i < 2; i++)
    begin
      // Upward offset enable stays clear, as software must keep it
      v = i ? 32'h00000000 : 32'hffdfffff;
      wr(8'h24, v);
      rdr(8'h24);
      chk(rd, v & 32'h00ffffff);  // read-write bits
      chk(PUMP_DN_UA, i ? 32'd0 : 32'd2540);  // sink current
      chk(PUMP_UP_UA, i ? 32'd0 : 32'd2540);  // source current
      chk(OFFSET_UA, i ? 32'd0 : 32'd635);  // offset current
      chk(PUMP_CTRL.high_current, {31'h0, !i});  // high current
    end
    // Every resolution, depth, clock code; edge and divider flags
    for (int i = 0; i < 8; i++)
    begin
      v = i | ((i % 4) << 8) | ((i % 4) << 13) | ((i % 2) << 15);
      v = v | ((i % 2) << 16);
      wr(8'h28, v);
      @(posedge CLK_SYS);
      chk(MEAS_CYCLES, (i < 4) ? (32'd1 << i) : (32'd1 << (i + 1)));
      chk(SAR_BITS, 32'd8 - (i % 4));  // depth decode
      chk(FSM_DIV, (i % 4) == 3 ? 32'd32 : (32'd1 << (2 * (i % 4))));
      chk(CAL_CFG.falling_edge, i % 2);  // edge select
      chk(CAL_CFG.rdiv_bypass, i % 2);  // divider bypass
    end
    // Unmapped place refused both ways
    wr(8'h3c, 32'h12345678);
    chk(resp, 32'h2);
    rdr(8'h3c);
    chk({rd[29:0], resp}, 32'h2);
    // Forced curve goes out unchanged
    cal(24'h000400, 8'h5a, 1'b0, n0);
    chk(VCO_CURVE, 32'h5a);  // forced curve
    rdr(8'h40);
    chk(rd[8:0], 32'h05a);
    // Search results with zero, minus, plus and saturating curve offsets, depth codes 0 and 3
    cal(24'h000000, 8'h00, 1'b0, n0);
    chk(VCO_CURVE, 32'hff);  // eight bits kept
    cal(24'h000038, 8'h00, 1'b0, n1);
    chk(VCO_CURVE, 32'hfe);  // minus one
    cal(24'h000018, 8'h00, 1'b1, n1);
    chk(VCO_CURVE, 32'h03);  // plus three
    cal(24'h000020, 8'h00, 1'b1, n1);
    chk(VCO_CURVE, 32'h00);  // minus four saturates
    cal(24'h000300, 8'h00, 1'b0, n1);
    chk(VCO_CURVE, 32'h1f);  // five bits
    // Extra waits and measurement length seen in run time
    cal(24'h0000c0, 8'h00, 1'b0, n1);
    chk(n1 - n0, 32'd300);  // three extra waits
    cal(24'h000007, 8'h00, 1'b0, n1);
    chk(n1 - n0, 32'd2040);  // longest measurement
    cal(24'h002000, 8'h00, 1'b0, n1);  // divide keeps clock in range
    chk(n1 > 4 * n0 - 8 && n1 < 4 * n0 + 8, 32'h1);  // slower ticks
    // Blocked trigger and bypass produce no transfer
    for (int i = 0; i < 2; i++)
    begin
      wr(8'h28, i ? 32'h00000800 : 32'h00001000);
      n0 = starts;
      wr(8'h14, 32'h000000aa);
      repeat (300) @(posedge CLK_SYS);
      chk(starts - n0, 32'd0);  // no start
      chk(CAL_BUSY, 32'h0);  // search skipped
      chk(VCO_CURVE, 32'hff);  // curve held
    end
    conclude();
  end
endmodule
